// *** hw/hpp_addr_ctrl.sv ***
// Address handling of the host parallel port: demultiplexed and indexed modes.
// Assumes host pins are synchronised here; strobes are one host access per pulse.
`timescale 1ns/10ps
module hpp_addr_ctrl
  import hpp_pkg::*;
#(
  parameter int HOST_AW = 16
) (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  // Mode straps from the process data port control
  input  wire logic                    indexed_mode_i,
  input  wire logic                    direct_mapped_i,
  input  wire logic                    bus16_i,
  // Host pins (asynchronous)
  input  wire logic [HOST_AW-1:0]      host_addr_i,
  input  wire logic                    host_endian_i,
  input  wire logic [1:0]              host_be_n_i,
  input  wire logic [15:0]             host_wdata_i,
  // Access strobes from the strobe logic, same clock
  input  wire logic                    acc_wr_i,
  input  wire logic                    acc_rd_i,
  // Internal request and local read data
  output hpp_pkg::hpp_req_type         req_o,
  output logic      [15:0]             local_rdata_o,
  output logic                         local_rvalid_o,
  // Configuration state
  output logic      [3:0]              endian_cfg_o
);

  import hpp_pkg::*;

  // Lane patterns of the internal request; a 16-bit host owns one half-word
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LANES_ALL  = 4'hf;
  localparam logic [3:0] LANES_LOW  = 4'h3;
  localparam logic [3:0] LANES_HIGH = 4'hc;
  localparam logic [3:0] LANE_FIRST = 4'h1;
  localparam int         LANE_BITS  = 8;
  localparam int         NIBBLE_W   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [HOST_AW-1:0] addr_s1_r;
  logic [HOST_AW-1:0] addr_s2_r;
  logic               endian_s1_r;
  logic               endian_s2_r;
  logic [1:0]         be_s1_r;
  logic [1:0]         be_s2_r;
  logic [15:0]        wdata_s1_r;
  logic [15:0]        wdata_s2_r;

  // One process per pin group; the strobe must trail the pins by two clocks
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_s1_r <= '0;
      addr_s2_r <= '0;
    end else begin
      addr_s1_r <= host_addr_i;
      addr_s2_r <= addr_s1_r;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      endian_s1_r <= 1'b0;
      endian_s2_r <= 1'b0;
    end else begin
      endian_s1_r <= host_endian_i;
      endian_s2_r <= endian_s1_r;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      be_s1_r <= 2'h0;
      be_s2_r <= 2'h0;
    end else begin
      be_s1_r <= host_be_n_i;
      be_s2_r <= be_s1_r;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdata_s1_r <= 16'h0000;
      wdata_s2_r <= 16'h0000;
    end else begin
      wdata_s1_r <= host_wdata_i;
      wdata_s2_r <= wdata_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indexed map decode

  logic [4:0] hoff;
  logic       sel_fifo;
  logic       sel_cfg;
  logic [1:0] pair;
  logic       sel_idx;
  logic       sel_data;

  // Bit 0 is absent on a 16-bit host
  assign hoff = bus16_i ? {addr_s2_r[4:1], 1'b0} : addr_s2_r[4:0];

  // Live decode; nothing latched between accesses
  always_comb begin
    sel_idx  = 1'b0;
    sel_data = 1'b0;
    sel_fifo = 1'b0;
    sel_cfg  = 1'b0;
    pair     = 2'd0;
    if ({hoff[4:2], 2'b00} == HPP_OFF_IDX0) begin
      sel_idx = 1'b1;
      pair    = 2'd0;
    end else if ({hoff[4:2], 2'b00} == HPP_OFF_DATA0) begin
      sel_data = 1'b1;
      pair     = 2'd0;
    end else if ({hoff[4:2], 2'b00} == HPP_OFF_IDX1) begin
      sel_idx = 1'b1;
      pair    = 2'd1;
    end else if ({hoff[4:2], 2'b00} == HPP_OFF_DATA1) begin
      sel_data = 1'b1;
      pair     = 2'd1;
    end else if ({hoff[4:2], 2'b00} == HPP_OFF_IDX2) begin
      sel_idx = 1'b1;
      pair    = 2'd2;
    end else if ({hoff[4:2], 2'b00} == HPP_OFF_DATA2) begin
      sel_data = 1'b1;
      pair     = 2'd2;
    end else if ({hoff[4:2], 2'b00} == HPP_OFF_FIFO) begin
      sel_fifo = !direct_mapped_i;
    end else begin
      sel_cfg = 1'b1;
    end
  end

  // Byte lane enables of a host write, positioned by address bits 1:0
  logic [3:0]  wr_lanes;
  logic [31:0] wr_word;

  always_comb begin
    wr_lanes = LANES_NONE;
    wr_word  = {wdata_s2_r, wdata_s2_r};
    if (bus16_i) begin
      wr_lanes = hoff[1] ? LANES_HIGH : LANES_LOW;
    end else begin
      wr_lanes = LANE_FIRST << hoff[1:0];
      wr_word  = {4{wdata_s2_r[7:0]}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access qualifiers

  logic idx_wr;
  logic cfg_wr;
  logic local_rd;

  // Index and config live only in the indexed map; demux never touches them
  assign idx_wr   = indexed_mode_i && acc_wr_i && sel_idx;
  assign cfg_wr   = indexed_mode_i && acc_wr_i && sel_cfg;
  assign local_rd = indexed_mode_i && acc_rd_i && (sel_idx || sel_cfg);

  ////////////////////////////////////////////////////////////////////////////
  // Index pointer registers

  logic [HPP_IDX_W-1:0] idx_val [HPP_NUM_PAIRS];

  for (genvar g = 0; g < HPP_NUM_PAIRS; g++) begin : g_idx
    logic [2:0] be;
    assign be = (idx_wr && pair == 2'(g))
                ? wr_lanes[2:0] : 3'h0;
    hpp_idx_reg #(
      .WIDTH     (HPP_IDX_W),
      .RST_VALUE (HPP_IDX_RST)
    ) u_idx (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .wr_be_i   (be),
      .wr_data_i (wr_word[23:0]),
      .value_o   (idx_val[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte order configuration

  logic [3:0] cfg_r;
  logic [3:0] cfg_set;

  // Any lane written with a one sets the bit; it clears only when every written lane holds zero
  always_comb begin
    cfg_set = 4'h0;
    for (int l = 0; l < 4; l++) begin
      if (wr_lanes[l]) cfg_set = cfg_set | wr_word[l*HPP_CFG_LANE_W +: NIBBLE_W];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r <= HPP_CFG_RST;
    end else if (cfg_wr) begin
      cfg_r <= cfg_set;
    end
  end

  assign endian_cfg_o = cfg_r;

  ////////////////////////////////////////////////////////////////////////////
  // Internal request formation

  logic [HPP_IADDR_W-1:0] sel_ptr;
  logic                   sel_bhe_n;
  hpp_req_type            req_nxt;
  hpp_req_type            req_r;

  assign sel_ptr   = idx_val[pair][HPP_IADDR_W-1:0];
  assign sel_bhe_n = idx_val[pair][HPP_BHE_BIT];

  logic [HPP_IADDR_W-1:0] step_addr;
  logic [HPP_IADDR_W-1:0] dword_addr;
  logic [HOST_AW-1:0]     demux_addr;

  // Direct mode walks core space as the host walks the window offsets
  assign step_addr  = sel_ptr + {{(HPP_IADDR_W-2){1'b0}}, hoff[1:0]};
  // Registers outside the core are whole doublewords, so the low bits drop
  assign dword_addr = {sel_ptr[HPP_IADDR_W-1:2], 2'b00};
  // A 16-bit host has no address line 0
  assign demux_addr = bus16_i ? {addr_s2_r[HOST_AW-1:1], 1'b0} : addr_s2_r;

  always_comb begin
    req_nxt         = '0;
    req_nxt.valid   = acc_wr_i || acc_rd_i;
    req_nxt.write   = acc_wr_i;
    req_nxt.lane    = hoff[1:0];
    req_nxt.target  = HPP_TGT_REG;
    req_nxt.byte_en = LANES_ALL;
    if (!indexed_mode_i) begin
      // Demux: pins used directly, no FIFO select
      req_nxt.addr       = demux_addr;
      req_nxt.big_endian = endian_s2_r;
      if (direct_mapped_i && bus16_i) begin
        req_nxt.byte_en = {2'b00, ~be_s2_r};
      end
    end else if (sel_fifo) begin
      req_nxt.target     = HPP_TGT_FIFO;
      req_nxt.big_endian = cfg_r[HPP_CFG_FIFO];
    end else if (sel_data) begin
      req_nxt.big_endian = cfg_r[pair];
      if (direct_mapped_i) begin
        req_nxt.addr = step_addr;
        if (bus16_i) begin
          // Active-low byte enables in the pointer
          req_nxt.byte_en = {2'b00, ~sel_bhe_n, ~sel_ptr[0]};
        end else begin
          req_nxt.byte_en = LANE_FIRST;
        end
      end else begin
        req_nxt.addr = dword_addr;
      end
    end else begin
      req_nxt.valid  = 1'b0;
      req_nxt.target = HPP_TGT_LOCAL;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  assign req_o = req_r;

  ////////////////////////////////////////////////////////////////////////////
  // Local register read-back

  logic [31:0] local_word;
  logic [15:0] rdata_r;
  logic        rvalid_r;

  always_comb begin
    local_word = 32'h0000_0000;
    if (sel_idx) begin
      local_word = {15'h0000, idx_val[pair]};
    end else if (sel_cfg) begin
      local_word = {4'h0, cfg_r, 4'h0, cfg_r, 4'h0, cfg_r, 4'h0, cfg_r};
    end
  end

  // Pulse marks the one cycle after a local register read; rdata_r holds that read's data then
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= local_rd;
    end
  end

  // Data follows the live lane even without a read; only the pulse qualifies it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 16'h0000;
    end else if (bus16_i) begin
      rdata_r <= hoff[1] ? local_word[31:16] : local_word[15:0];
    end else begin
      rdata_r <= {8'h00, local_word[hoff[1:0]*LANE_BITS +: LANE_BITS]};
    end
  end

  assign local_rdata_o  = rdata_r;
  assign local_rvalid_o = rvalid_r;

endmodule // hpp_addr_ctrl

// *** hw/hpp_pkg.sv ***
// Package for the host parallel port address and index block.
// Assumes a single 100 MHz clock domain shared with the host bus logic.
package hpp_pkg;

  // Host map offsets in indexed mode (byte addresses)
  localparam logic [4:0] HPP_OFF_IDX0  = 5'h00;
  localparam logic [4:0] HPP_OFF_DATA0 = 5'h04;
  localparam logic [4:0] HPP_OFF_IDX1  = 5'h08;
  localparam logic [4:0] HPP_OFF_DATA1 = 5'h0c;
  localparam logic [4:0] HPP_OFF_IDX2  = 5'h10;
  localparam logic [4:0] HPP_OFF_DATA2 = 5'h14;
  localparam logic [4:0] HPP_OFF_FIFO  = 5'h18;
  localparam logic [4:0] HPP_OFF_CFG   = 5'h1c;

  // Field layout and reset values
  localparam int          HPP_NUM_PAIRS   = 3;
  localparam int          HPP_IDX_W       = 17;
  localparam int          HPP_IADDR_W     = 16;
  localparam int          HPP_BHE_BIT     = 16;
  localparam logic [16:0] HPP_IDX_RST     = 17'h01234;
  localparam logic [3:0]  HPP_CFG_RST     = 4'h0;
  localparam int          HPP_CFG_LANE_W  = 8;
  localparam int          HPP_CFG_FIFO    = 3;
  localparam int          HPP_HOST_AW     = 16;

  // Endianness encoding of each control bit
  localparam logic HPP_LITTLE = 1'b0;
  localparam logic HPP_BIG    = 1'b1;

  typedef enum logic [1:0] {
    HPP_TGT_REG,
    HPP_TGT_FIFO,
    HPP_TGT_LOCAL
  } hpp_target_type;

  // Internal access request handed to the core side
  typedef struct packed {
    logic                   valid;
    logic                   write;
    hpp_target_type         target;
    logic [HPP_HOST_AW-1:0] addr;
    logic [3:0]             byte_en;
    logic                   big_endian;
    logic [1:0]             lane;
  } hpp_req_type;

endpackage

// *** hw/hpp_idx_reg.sv ***
// One index pointer register with per-byte immediate update.
// Assumes write strobes come from logic on the same clock.
`timescale 1ns/10ps
module hpp_idx_reg #(
  parameter int          WIDTH     = 17,
  parameter logic [16:0] RST_VALUE = 17'h01234
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Write port
  input  wire logic [2:0]       wr_be_i,
  input  wire logic [23:0]      wr_data_i,
  // State
  output logic      [WIDTH-1:0] value_o
);

  logic [WIDTH-1:0] value_r;

  // Bytes land at once, no doubleword assembly; value held otherwise
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      value_r <= RST_VALUE[WIDTH-1:0];
    end else begin
      if (wr_be_i[0]) value_r[7:0]  <= wr_data_i[7:0];
      if (wr_be_i[1]) value_r[15:8] <= wr_data_i[15:8];
      if (wr_be_i[2]) value_r[16]   <= wr_data_i[16];
    end
  end

  assign value_o = value_r;

endmodule // hpp_idx_reg

// *** bench/hpp_addr_ctrl_assertions.sv ***
// Port-level checker for the host port address block.
// Assumes one clock domain; bound onto every hpp_addr_ctrl instance.
`timescale 1ns/10ps
module hpp_addr_ctrl_chk
  import hpp_pkg::*;
(
  // Clock, reset and mode
  input wire logic         clk_i,
  input wire logic         nrst_i,
  input wire logic         indexed_mode_i,
  input wire logic         direct_mapped_i,
  input wire logic         bus16_i,
  // Strobes and results
  input wire logic         acc_wr_i,
  input wire logic         acc_rd_i,
  input hpp_pkg::hpp_req_type req_o,
  input wire logic         local_rvalid_o,
  input wire logic   [3:0] endian_cfg_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////
  req_cause_a: assert property (req_o.valid |-> $past(acc_wr_i || acc_rd_i))
    else $error("request without strobe");
  write_dir_a: assert property (req_o.valid |-> req_o.write == $past(acc_wr_i))
    else $error("request direction wrong");
  rvalid_cause_a: assert property (local_rvalid_o |-> $past(acc_rd_i))
    else $error("local read data without read");
  demux_fifo_a: assert property (req_o.valid && !$past(indexed_mode_i)
    |-> req_o.target != HPP_TGT_FIFO) else $error("fifo select in demux mode");
  direct_fifo_a: assert property (req_o.valid && $past(direct_mapped_i)
    |-> req_o.target != HPP_TGT_FIFO) else $error("fifo access in direct mode");
  cfg_hold_a: assert property (!$stable(endian_cfg_o) |-> $past(acc_wr_i))
    else $error("config changed without write");
  reg_align_a: assert property (req_o.valid && req_o.target == HPP_TGT_REG
    && $past(indexed_mode_i && !direct_mapped_i)
    |-> req_o.addr[1:0] == 2'h0 && req_o.byte_en == 4'hf) else $error("unaligned reg access");
  byte_lane_a: assert property (req_o.valid
    && $past(indexed_mode_i && direct_mapped_i && !bus16_i)
    |-> req_o.byte_en == 4'h1) else $error("direct byte access width wrong");
  ptr_lanes_a: assert property (req_o.valid
    && $past(indexed_mode_i && direct_mapped_i && bus16_i)
    |-> req_o.byte_en[3:2] == 2'h0) else $error("direct word access lanes wrong");
  cover property (req_o.valid && req_o.target == HPP_TGT_FIFO);
  cover property (req_o.valid && req_o.byte_en == 4'h2);
  cover property (local_rvalid_o);
  cover property ($rose(endian_cfg_o[0]));
endmodule // hpp_addr_ctrl_chk

bind hpp_addr_ctrl hpp_addr_ctrl_chk u_chk (.clk_i, .nrst_i, .indexed_mode_i,
  .direct_mapped_i, .bus16_i, .acc_wr_i, .acc_rd_i, .req_o, .local_rvalid_o, .endian_cfg_o);

// *** bench/hpp_host_model.sv ***
// Host model: drives address, data and one-cycle access strobes.
// Assumes the bench drives nothing else on these pins.
`timescale 1ns/10ps
module hpp_host_model (
  // Clock and mode
  input  wire logic        clk_i,
  input  wire logic        bus16_i,
  // Host pins
  output logic      [15:0] addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  initial begin
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  ////////////////////////////////////////
  // Undecoded pins carry noise so a decode that peeks at them shows up
  task automatic access(input logic w, full, input logic [15:0] a, d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    if (!full) addr_o[15:5] = 11'($urandom);
    if (!full && bus16_i) addr_o[0] = 1'($urandom);
    if (!bus16_i) wdata_o[15:8] = 8'($urandom);
    // Pins need two synchroniser stages before the strobe
    repeat (3) @(negedge clk_i);
    wr_o = w;
    rd_o = !w;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
  endtask
endmodule // hpp_host_model

// *** bench/tb.sv ***
// Self-checking bench for hpp_addr_ctrl.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module tb;
  import hpp_pkg::*;
  logic        clk_i, nrst_i, indexed_mode_i, direct_mapped_i, bus16_i;
  logic        host_endian_i, acc_wr_i, acc_rd_i, local_rvalid_o;
  logic [1:0]  host_be_n_i;
  logic [15:0] host_addr_i, host_wdata_i, local_rdata_o, d;
  logic [3:0]  endian_cfg_o;
  hpp_req_type req_o;
  int          fail_count, num_checks;
  logic [22:0] rq[$];
  logic [15:0] lq[$];

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  hpp_addr_ctrl u_hpp_addr_ctrl (.clk_i, .nrst_i, .indexed_mode_i, .direct_mapped_i,
    .bus16_i, .host_addr_i, .host_endian_i, .host_be_n_i, .host_wdata_i, .acc_wr_i,
    .acc_rd_i, .req_o, .local_rdata_o, .local_rvalid_o, .endian_cfg_o);
  hpp_host_model u_hpp_host_model (.clk_i, .bus16_i, .addr_o(host_addr_i),
    .wdata_o(host_wdata_i), .wr_o(acc_wr_i), .rd_o(acc_rd_i));
  ////////////////////////////////////////
  task automatic check(input string n, input logic [22:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic mode(input logic i, dm, b);
    @(negedge clk_i);
    indexed_mode_i = i;
    direct_mapped_i = dm;
    bus16_i = b;
  endtask
  task automatic acc(input logic w, input logic [15:0] a, dd);
    u_hpp_host_model.access(w, !indexed_mode_i, a, dd);
  endtask
  ////////////////////////////////////////
  // Fifo addresses are not defined at the port, so the address is masked; target, endianness and byte enables are compared
  always @(posedge clk_i) begin
    #1;
    if (req_o.valid === 1'b1) check("req", {req_o.target, req_o.big_endian,
      req_o.byte_en, req_o.target == HPP_TGT_FIFO ? 16'h0 : req_o.addr},
      rq.size() ? rq.pop_front() : 'x);
    if (local_rvalid_o === 1'b1) check("rdata", bus16_i ? local_rdata_o
      : {8'h00, local_rdata_o[7:0]}, lq.size() ? lq.pop_front() : 'x);
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    final_report();
  end
  initial begin
    nrst_i = 1'b0;
    host_endian_i = 1'b0;
    host_be_n_i = 2'h0;
    fail_count = 0;
    num_checks = 0;
    indexed_mode_i = 1'b1;
    direct_mapped_i = 1'b0;
    bus16_i = 1'b1;
    void'($urandom(40372));
    repeat (20) @(posedge clk_i);
    @(negedge clk_i) nrst_i = 1'b1;
    lq.push_back(16'h1234);
    acc(0, 16'h00, 0);
    acc(1, 16'h1e, 16'h0008);
    @(posedge clk_i) #1 check("cfg", endian_cfg_o, 4'h8);
    lq.push_back(16'h0808);
    acc(0, 16'h1c, 0);
    rq.push_back({HPP_TGT_FIFO, 1'b1, 4'hf, 16'h0});
    acc(1, 16'h18, 16'($urandom));
    acc(1, 16'h1c, 16'h0000);
    @(posedge clk_i) #1 check("cfg", endian_cfg_o, 4'h0);
    mode(1, 0, 0);
    lq.push_back(16'h12);
    acc(0, 16'h09, 0);
    acc(1, 16'h08, 16'h7b);
    acc(1, 16'h09, 16'h56);
    rq.push_back({HPP_TGT_REG, 1'b0, 4'hf, 16'h5678});
    acc(0, 16'h0d, 0);
    rq.push_back({HPP_TGT_REG, 1'b0, 4'hf, 16'h1234});
    acc(1, 16'h04, 16'($urandom));
    lq.push_back(16'h56);
    acc(0, 16'h09, 0);
    rq.push_back({HPP_TGT_FIFO, 1'b0, 4'hf, 16'h0});
    acc(1, 16'h18, 16'h33);
    acc(1, 16'h1e, 16'h01);
    @(posedge clk_i) #1 check("cfg", endian_cfg_o, 4'h1);
    lq.push_back(16'h01);
    acc(0, 16'h1f, 0);
    rq.push_back({HPP_TGT_REG, 1'b1, 4'hf, 16'h1234});
    acc(0, 16'h07, 0);
    acc(1, 16'h1c, 16'h00);
    @(posedge clk_i) #1 check("cfg", endian_cfg_o, 4'h0);
    mode(1, 1, 0);
    rq.push_back({HPP_TGT_REG, 1'b0, 4'h1, 16'h567d});
    acc(0, 16'h0e, 0);
    acc(1, 16'h18, 16'h33);
    mode(1, 1, 1);
    acc(1, 16'h00, 16'h4320);
    acc(1, 16'h02, 16'h0001);
    rq.push_back({HPP_TGT_REG, 1'b0, 4'h1, 16'h4322});
    acc(0, 16'h06, 0);
    acc(1, 16'h00, 16'h4321);
    acc(1, 16'h02, 16'h0000);
    rq.push_back({HPP_TGT_REG, 1'b0, 4'h2, 16'h4321});
    acc(0, 16'h04, 0);
    mode(0, 0, 0);
    host_endian_i = 1'b1;
    rq.push_back({HPP_TGT_REG, 1'b1, 4'hf, 16'h0123});
    acc(0, 16'h0123, 0);
    host_endian_i = 1'b0;
    mode(0, 0, 1);
    rq.push_back({HPP_TGT_REG, 1'b0, 4'hf, 16'h0122});
    acc(0, 16'h0123, 0);
    mode(0, 1, 1);
    host_be_n_i = 2'h2;
    rq.push_back({HPP_TGT_REG, 1'b0, 4'h1, 16'h0456});
    acc(0, 16'h0457, 0);
    host_be_n_i = 2'h0;
    mode(1, 0, 0);
    repeat (4) begin
      d = 16'($urandom);
      acc(1, 16'h10, {8'h00, d[7:0]});
      acc(1, 16'h11, {8'h00, d[15:8]});
      rq.push_back({HPP_TGT_REG, 1'b0, 4'hf, d[15:2], 2'h0});
      acc(0, 16'h14 + 16'($urandom_range(3)), 0);
    end
    @(negedge clk_i) nrst_i = 1'b0;
    @(negedge clk_i) nrst_i = 1'b1;
    lq.push_back(16'h34);
    acc(0, 16'h10, 0);
    repeat (4) @(posedge clk_i);
    check("left", rq.size() + lq.size(), 0);
    final_report();
  end
endmodule // tb
